//--- accel_i2c_pkg.sv
// Shared constants and types for the accelerometer two-wire slave port
package accel_i2c_pkg;

    // Sample and byte geometry
    localparam int         SAMPLE_BITS = 12;
    localparam int         SAMPLE_WORD = 3 * SAMPLE_BITS;
    localparam int         FIFO_DEPTH  = 4;
    localparam logic [3:0] BIT_LAST    = 4'h8;

    // Slave address: fixed upper nibble, factory low bits elsewhere
    localparam logic [3:0] ADDR_FIXED  = 4'h2;

    // Readout positions
    localparam logic [2:0] IDX_CONTROL = 3'h0;
    localparam logic [2:0] IDX_X_HIGH  = 3'h1;
    localparam logic [2:0] IDX_X_LOW   = 3'h2;
    localparam logic [2:0] IDX_Y_HIGH  = 3'h3;
    localparam logic [2:0] IDX_Y_LOW   = 3'h4;
    localparam logic [7:0] INDEX_WRITE = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // Control register fields and reset value
    localparam int         CTRL_SLEEP      = 0;
    localparam int         CTRL_SELF_CHECK = 1;
    localparam int         CTRL_REF_TRIM   = 2;
    localparam int         CTRL_THERMAL    = 3;
    localparam logic [7:0] CTRL_RESET      = 8'h00;

    // Link sequencer states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX       = 3'b011,
        ST_RX_ACK   = 3'b100,
        ST_TX       = 3'b101,
        ST_TX_ACK   = 3'b110
    } link_state_t;

endpackage

//--- sample_if.sv
// Carrier for one sample word between the buffer and the link logic
`timescale 1ns/1ps
interface sample_if #(parameter int WIDTH = 36);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- pin_sync.sv
// Two-stage synchroniser with one extra stage kept for edge finding
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Pins and synchronised copies
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] prev_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] prev;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // Shift chain; only the second stage reads the first
    always_comb
    begin
        s_d       = s_q;
        s_d.meta  = pin_i;
        s_d.level = s_q.meta;
        s_d.prev  = s_q.level;
    end

    // Idle bus lines are high
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '1;
        else
            s_q <= s_d;
    end

    assign level_o = s_q.level;
    assign prev_o  = s_q.prev;
endmodule // pin_sync

//--- sample_fifo.sv
// Small sample buffer between the converter and the readout
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Filling side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Draining side
    sample_if.src                 out_if
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    if (DEPTH < 2 || DEPTH != (1 << AW) || WIDTH < 1)
    begin : g_bad_shape
        $error("sample_fifo needs a power-of-two depth of at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic                        rdy;
    } fifo_t;

    fifo_t s_q;
    fifo_t s_d;
    logic  push;
    logic  pop;

    // Pointer, count and registered ready update
    always_comb
    begin
        s_d  = s_q;
        push = in_valid_i && s_q.rdy;
        pop  = out_if.ready && (s_q.cnt != '0);
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop)
            s_d.rd = s_q.rd + 1'b1;
        if (push && !pop)
            s_d.cnt = s_q.cnt + 1'b1;
        else if (pop && !push)
            s_d.cnt = s_q.cnt - 1'b1;
        s_d.rdy = (s_d.cnt != FULL);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q     <= '0;
            s_q.rdy <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign in_ready_o   = s_q.rdy;
    assign out_if.valid = (s_q.cnt != '0);
    assign out_if.data  = s_q.mem[s_q.rd];
endmodule // sample_fifo

//--- accel_i2c_slave_regs.sv
// Two-wire slave port: address decode, control register and five-byte readout
`timescale 1ns/1ps
// Notes on behaviour
// - Data line changes only while clock is low; stable through clock high.
// - Each byte is eight bits plus one acknowledge, nine clocks in all.
// - Bytes travel most significant bit first in both directions.
// - Answer only address with fixed upper nibble and factory-set low three bits.
// - Eighth address bit: one is a read, zero is a write.
// - Pull data low on ninth clock after address and each written byte.
// - Control bit 0 set requests sleep.
// - Control bit 0 clear wakes; that write precedes acceleration readout.
// - Control bit 1 enables self-check; clearing returns to normal.
// - Control bit 3 swaps the X byte pair for the temperature reading.
// - Read sends a byte per nine clocks while acked: control, XH, XL, YH, YL.
// - Read pointer steps by one after every byte transferred.
// - Positions five to seven read zero, then pointer wraps to zero.
// - One index byte sets the read start; X high byte is index one.
// - Axis values have 12 or 10 significant bits; unused high bits read zero.
// - Ten-bit results refresh at 400 Hz, twelve-bit at 100 Hz.
// - Position zero reads back the current control register.
module accel_i2c_slave_regs #(
    parameter logic [2:0] ADDR_LOW  = 3'h0,
    parameter int         DATA_BITS = 12
) (
    // Clock and reset
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_n_i,
    // Two-wire bus pins
    input  wire logic                                 scl_i,
    input  wire logic                                 sda_i,
    output logic                                      sda_o,
    output logic                                      sda_oe_o,
    // Converter samples
    input  wire logic                                 sample_valid_i,
    input  wire logic [accel_i2c_pkg::SAMPLE_BITS-1:0] sample_x_i,
    input  wire logic [accel_i2c_pkg::SAMPLE_BITS-1:0] sample_y_i,
    input  wire logic [accel_i2c_pkg::SAMPLE_BITS-1:0] sample_temp_i,
    output logic                                      sample_ready_o,
    // Control register outputs
    output logic                                      sleep_request_o,
    output logic                                      self_check_enable_o,
    output logic                                      reference_trim_toggle_o,
    output logic                                      thermal_output_select_o
);
    import accel_i2c_pkg::*;

    if (DATA_BITS != 10 && DATA_BITS != 12)
    begin : g_bad_bits
        $error("accel_i2c_slave_regs serves only 10 or 12 significant bits");
    end

    localparam logic [15:0] VALUE_MASK = 16'((32'h0000_0001 << DATA_BITS) - 1);

    typedef struct packed {
        link_state_t            st;
        logic [3:0]             cnt;
        logic [7:0]             shift;
        logic [7:0]             tx;
        logic [2:0]             ptr;
        logic                   rw;
        logic                   idx_phase;
        logic                   idx_ok;
        logic                   acked;
        logic                   oe;
        logic                   sda_out;
        logic [7:0]             ctrl;
        logic [SAMPLE_WORD-1:0] snap;
    } slave_t;

    slave_t s_q;
    slave_t s_d;

    logic [1:0]             rst_sync_q;
    logic                   rst_n;
    logic [1:0]             line_level;
    logic [1:0]             line_prev;
    logic                   scl_s;
    logic                   scl_p;
    logic                   sda_s;
    logic                   sda_p;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start_seen;
    logic                   stop_seen;
    logic                   addr_hit;
    logic [SAMPLE_WORD-1:0] snap_next;
    logic [7:0]             byte_now;
    logic [7:0]             byte_next;

    sample_if #(.WIDTH(SAMPLE_WORD)) buf_if ();

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Bus pins into the clock domain
    pin_sync #(.WIDTH(2)) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .pin_i   ({scl_i, sda_i}),
        .level_o (line_level),
        .prev_o  (line_prev)
    );

    // Sample buffer; the converter stalls when it is full
    sample_fifo #(.WIDTH(SAMPLE_WORD), .DEPTH(FIFO_DEPTH)) u_sample_fifo (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .in_valid_i (sample_valid_i),
        .in_data_i  ({sample_temp_i, sample_x_i, sample_y_i}),
        .in_ready_o (sample_ready_o),
        .out_if     (buf_if.src)
    );

    // Clock edges and bus conditions
    assign scl_s      = line_level[1];
    assign sda_s      = line_level[0];
    assign scl_p      = line_prev[1];
    assign sda_p      = line_prev[0];
    assign scl_rise   = scl_s && !scl_p;
    assign scl_fall   = !scl_s && scl_p;
    assign start_seen = scl_s && scl_p && sda_p && !sda_s;
    assign stop_seen  = scl_s && scl_p && !sda_p && sda_s;
    assign addr_hit   = (s_q.shift[7:1] == {ADDR_FIXED, ADDR_LOW});

    // Readout byte for a position, with unused high bits cleared
    function automatic logic [7:0] read_byte(input logic [2:0]             pos,
                                             input logic [7:0]             ctrl,
                                             input logic [SAMPLE_WORD-1:0] snap);
        logic [15:0] xval;
        logic [15:0] yval;
        logic [7:0]  res;
        xval = {4'h0, ctrl[CTRL_THERMAL] ? snap[3*SAMPLE_BITS-1:2*SAMPLE_BITS]
                                         : snap[2*SAMPLE_BITS-1:SAMPLE_BITS]} & VALUE_MASK;
        yval = {4'h0, snap[SAMPLE_BITS-1:0]} & VALUE_MASK;
        unique case (pos)
            IDX_CONTROL: res = ctrl;
            IDX_X_HIGH:  res = xval[15:8];
            IDX_X_LOW:   res = xval[7:0];
            IDX_Y_HIGH:  res = yval[15:8];
            IDX_Y_LOW:   res = yval[7:0];
            default:     res = BYTE_ZERO;
        endcase
        return res;
    endfunction

    // One sample is taken per read so both bytes of an axis match
    assign buf_if.ready = (s_q.st == ST_ADDR_ACK) && scl_fall && s_q.rw && !start_seen && !stop_seen;
    assign snap_next    = buf_if.valid ? buf_if.data : s_q.snap;
    assign byte_now     = read_byte(s_q.ptr, s_q.ctrl, snap_next);
    assign byte_next    = read_byte(s_q.ptr, s_q.ctrl, s_q.snap);

    // Link sequencer
    always_comb
    begin
        s_d = s_q;
        if (stop_seen)
        begin
            s_d.st = ST_IDLE;
            s_d.oe = 1'b0;
        end
        else if (start_seen)
        begin
            s_d.st  = ST_ADDR;
            s_d.cnt = 4'h0;
            s_d.oe  = 1'b0;
        end
        else
        begin
            unique case (s_q.st)
                ST_IDLE:
                begin
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        s_d.shift = {s_q.shift[6:0], sda_s};
                        s_d.cnt   = s_q.cnt + 4'h1;
                    end
                    else if (scl_fall && s_q.cnt == BIT_LAST)
                    begin
                        if (addr_hit)
                        begin
                            s_d.oe = 1'b1;
                            s_d.rw = s_q.shift[0];
                            s_d.st = ST_ADDR_ACK;
                        end
                        else
                            s_d.st = ST_IDLE;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        s_d.cnt = 4'h0;
                        if (s_q.rw)
                        begin
                            s_d.snap = snap_next;
                            s_d.tx   = byte_now;
                            s_d.oe   = ~byte_now[7];
                            s_d.st   = ST_TX;
                        end
                        else
                        begin
                            s_d.oe        = 1'b0;
                            s_d.idx_phase = 1'b1;
                            s_d.st        = ST_RX;
                        end
                    end
                end
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        s_d.shift = {s_q.shift[6:0], sda_s};
                        s_d.cnt   = s_q.cnt + 4'h1;
                    end
                    else if (scl_fall && s_q.cnt == BIT_LAST)
                    begin
                        s_d.oe        = 1'b1;
                        s_d.idx_phase = 1'b0;
                        s_d.st        = ST_RX_ACK;
                        if (s_q.idx_phase)
                        begin
                            s_d.ptr    = s_q.shift[2:0];
                            s_d.idx_ok = (s_q.shift == INDEX_WRITE);
                        end
                        else
                        begin
                            if (s_q.idx_ok)
                                s_d.ctrl = s_q.shift;
                            s_d.idx_ok = 1'b0;
                            s_d.ptr    = s_q.ptr + 3'h1;
                        end
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        s_d.oe  = 1'b0;
                        s_d.cnt = 4'h0;
                        s_d.st  = ST_RX;
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                        s_d.cnt = s_q.cnt + 4'h1;
                    else if (scl_fall)
                    begin
                        if (s_q.cnt == BIT_LAST)
                        begin
                            s_d.oe  = 1'b0;
                            s_d.ptr = s_q.ptr + 3'h1;
                            s_d.st  = ST_TX_ACK;
                        end
                        else
                        begin
                            s_d.tx = {s_q.tx[6:0], 1'b0};
                            s_d.oe = ~s_q.tx[6];
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        s_d.acked = ~sda_s;
                    else if (scl_fall)
                    begin
                        if (s_q.acked)
                        begin
                            s_d.cnt = 4'h0;
                            s_d.tx  = byte_next;
                            s_d.oe  = ~byte_next[7];
                            s_d.st  = ST_TX;
                        end
                        else
                            s_d.st = ST_IDLE;
                    end
                end
                default:
                    s_d.st = ST_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q      <= '0;
            s_q.st   <= ST_IDLE;
            s_q.ctrl <= CTRL_RESET;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from state flops
    assign sda_o                   = s_q.sda_out;
    assign sda_oe_o                = s_q.oe;
    assign sleep_request_o         = s_q.ctrl[CTRL_SLEEP];
    assign self_check_enable_o     = s_q.ctrl[CTRL_SELF_CHECK];
    assign reference_trim_toggle_o = s_q.ctrl[CTRL_REF_TRIM];
    assign thermal_output_select_o = s_q.ctrl[CTRL_THERMAL];

    // Checks on the sequencer
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    AST_DRIVE_LOW_CLOCK: assert property ($rose(s_q.oe) |-> !scl_s)
        else $error("data line pulled while clock high");

    AST_NINE_CLOCKS: assert property ((s_q.st == ST_RX || s_q.st == ST_TX) |-> s_q.cnt <= BIT_LAST)
        else $error("byte ran past eight bits");

    AST_MSB_FIRST: assert property ((s_q.st == ST_ADDR_ACK && scl_fall && s_q.rw && !stop_seen && !start_seen)
                                    |=> (s_q.oe == ~s_q.tx[7]) && s_q.st == ST_TX)
        else $error("first read bit is not the top bit");

    AST_ADDR_MISS: assert property ((s_q.st == ST_ADDR && scl_fall && s_q.cnt == BIT_LAST && !addr_hit
                                     && !start_seen && !stop_seen) |=> s_q.st == ST_IDLE && !s_q.oe)
        else $error("foreign address answered");

    AST_DIRECTION: assert property ((s_q.st == ST_ADDR && scl_fall && s_q.cnt == BIT_LAST && addr_hit
                                     && !start_seen && !stop_seen) |=> s_q.rw == $past(s_q.shift[0]))
        else $error("direction bit not kept");

    AST_ACK_HELD: assert property ((s_q.st == ST_ADDR_ACK || s_q.st == ST_RX_ACK) |-> s_q.oe)
        else $error("acknowledge not driven");

    AST_CTRL_WRITE: assert property ((s_q.st == ST_RX && scl_fall && s_q.cnt == BIT_LAST && !s_q.idx_phase
                                      && s_q.idx_ok && !start_seen && !stop_seen)
                                     |=> sleep_request_o == $past(s_q.shift[0])
                                         && self_check_enable_o == $past(s_q.shift[1]))
        else $error("control write not applied");

    AST_CTRL_IGNORED: assert property ((s_q.st == ST_RX && scl_fall && s_q.cnt == BIT_LAST && !s_q.idx_phase
                                        && !s_q.idx_ok) |=> $stable(s_q.ctrl))
        else $error("control changed after nonzero index");

    AST_PTR_STEP: assert property ((s_q.st == ST_TX && scl_fall && s_q.cnt == BIT_LAST
                                    && !start_seen && !stop_seen) |=> s_q.ptr == $past(s_q.ptr) + 3'h1)
        else $error("read pointer did not step");

    AST_ZERO_TAIL: assert property ((s_q.ptr > IDX_Y_LOW) |-> byte_next == BYTE_ZERO)
        else $error("positions past the fifth not zero");

    AST_CTRL_READBACK: assert property ((s_q.ptr == IDX_CONTROL) |-> byte_next == s_q.ctrl)
        else $error("position zero not control register");

    AST_HIGH_ZERO: assert property ((s_q.ptr == IDX_Y_HIGH) |-> byte_next[7:DATA_BITS-8] == '0)
        else $error("unused high bits not zero");
endmodule // accel_i2c_slave_regs

//--- i2c_master_model.sv
// Two-wire bus master model driving the clock and pulling data low
`timescale 1ns/1ps
module i2c_master_model (
    // Clock and resolved data line
    input  wire logic clk_i,
    input  wire logic sda_line_i,
    // Bus drive
    output logic      scl_o,
    output logic      sda_pull_o
);
    // Bus idle at time zero
    initial
    begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end
    // Wait some system clocks
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Start or repeated start
    task automatic start();
        sda_pull_o <= 1'b0;
        hold(8);
        scl_o <= 1'b1;
        hold(8);
        sda_pull_o <= 1'b1;
        hold(8);
        scl_o <= 1'b0;
        hold(8);
    endtask
    // Stop: data released while clock high
    task automatic stop();
        sda_pull_o <= 1'b1;
        hold(8);
        scl_o <= 1'b1;
        hold(8);
        sda_pull_o <= 1'b0;
        hold(8);
    endtask
    // One bit, data set while clock low, sampled mid high
    task automatic bit_cycle(input logic b, output logic r);
        sda_pull_o <= ~b;
        hold(8);
        scl_o <= 1'b1;
        hold(8);
        r = sda_line_i;
        hold(8);
        scl_o <= 1'b0;
        hold(8);
    endtask
    // Eight bits MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_r);
        for (int i = 7; i >= 0; i--)
            bit_cycle(d[i], q[i]);
        bit_cycle(ack_in, ack_r);
    endtask
endmodule // i2c_master_model

//--- test_accel_i2c_slave_regs.sv
// Testbench for the accelerometer two-wire slave port
`timescale 1ns/1ps
module test_accel_i2c_slave_regs;
    import accel_i2c_pkg::*;
    // Clock, reset and bus
    logic                   clk_i;
    logic                   rst_n_i;
    logic                   scl;
    logic                   sda_pull;
    logic                   sda_o;
    logic                   sda_oe_o;
    wire logic              sda_line;
    // Samples, control outputs, bookkeeping
    logic                   sample_valid_i;
    logic [SAMPLE_BITS-1:0] sx;
    logic [SAMPLE_BITS-1:0] sy;
    logic [SAMPLE_BITS-1:0] st;
    logic                   sample_ready_o;
    logic [3:0]             ctrl_o;
    logic [7:0]             q;
    logic                   ack;
    logic [6:0]             adr;
    int                     error_cnt;
    int                     cmp_count;
    // Wired-AND with pull-up
    assign sda_line = ~(sda_pull | (sda_oe_o & ~sda_o));
    assign adr = {ADDR_FIXED, 3'h5};
    // Unit under test and bus master model
    accel_i2c_slave_regs #(.ADDR_LOW(3'h5), .DATA_BITS(12)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sample_valid_i(sample_valid_i),
        .sample_x_i(sx), .sample_y_i(sy), .sample_temp_i(st), .sample_ready_o(sample_ready_o),
        .sleep_request_o(ctrl_o[0]), .self_check_enable_o(ctrl_o[1]),
        .reference_trim_toggle_o(ctrl_o[2]), .thermal_output_select_o(ctrl_o[3]));
    i2c_master_model m (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull));
    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            error_cnt++;
        end
    endtask
    // Verdict
    task automatic close_out();
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Master writes a byte and checks the answer bit
    task automatic send(input logic [7:0] b, input logic e, input string name);
        m.xfer(b, 1'b1, q, ack);
        check(name, {7'h00, ack}, {7'h00, e});
    endtask
    // Offer one converter sample
    task automatic put_sample(input logic [11:0] x, input logic [11:0] y, input logic [11:0] t);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        sx <= x;
        sy <= y;
        st <= t;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
    endtask
    // Index and control write
    task automatic wr_ctrl(input logic [7:0] idx, input logic [7:0] c);
        m.start();
        send({adr, 1'b0}, 1'b0, "addr_ack");
        send(idx, 1'b0, "index_ack");
        send(c, 1'b0, "ctrl_ack");
        m.stop();
    endtask
    // Index write, repeated start, burst read
    task automatic rd(input logic [2:0] idx, input int n, input logic [7:0] exp [8]);
        m.start();
        send({adr, 1'b0}, 1'b0, "addr_ack");
        send({5'h00, idx}, 1'b0, "index_ack");
        m.start();
        send({adr, 1'b1}, 1'b0, "read_addr_ack");
        for (int i = 0; i < n; i++)
        begin
            m.xfer(8'hFF, i == n - 1, q, ack);
            check("read_byte", q, exp[i]);
        end
        m.stop();
    endtask
    // Main sequence
    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        rst_n_i = 1'b0;
        sample_valid_i = 1'b0;
        sx = '0;
        sy = '0;
        st = '0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("ctrl_reset", {4'h0, ctrl_o}, CTRL_RESET);
        check("sample_ready", {7'h00, sample_ready_o}, 8'h01);
        // Sleep plus thermal select, full burst over all eight positions
        put_sample(12'hABC, 12'h123, 12'h456);
        wr_ctrl(8'h00, 8'h09);
        check("ctrl_out", {4'h0, ctrl_o}, 8'h09);
        rd(3'h0, 8, '{8'h09, 8'h04, 8'h56, 8'h01, 8'h23, 8'h00, 8'h00, 8'h00});
        // Wake with self-check and trim, read from X high
        wr_ctrl(8'h00, 8'h06);
        check("ctrl_out", {4'h0, ctrl_o}, 8'h06);
        put_sample(12'hFED, 12'h321, 12'h654);
        rd(3'h1, 2, '{8'h0F, 8'hED, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        // Control byte behind a nonzero index is ignored
        wr_ctrl(8'h01, 8'h01);
        check("ctrl_kept", {4'h0, ctrl_o}, 8'h06);
        // Foreign address gets no answer
        m.start();
        send({ADDR_FIXED, 3'h0, 1'b0}, 1'b1, "foreign_nack");
        m.stop();
        close_out();
    end
endmodule // test_accel_i2c_slave_regs
